// *** hw/ulc_uart_line_config.sv ***
// Implementation choice: strobed register access.
`timescale 1ns/10ps
module ulc_uart_line_config
   import ulc_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Register port
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   output logic [7:0] RDATA,
   // Serial line
   input wire logic SERIAL_IN_PIN,
   output logic SERIAL_OUT_PIN,
   // Auxiliary baud timer match pulse
   input wire logic AUX_TIMER_MATCH_EVENT,
   // Interrupt
   output logic IRQ
);

   typedef struct packed {
      ulc_line_ctrl_t ctrl;
      ulc_rx_opt_t ropt;
      logic [7:0] tbuf;
      logic tfull;
      ulc_tx_state_t tst;
      logic [3:0] tph;
      logic [2:0] tbit;
      logic [7:0] tsh;
      logic tpar;
      logic tsec;
      logic tout;
      ulc_rx_state_t rst;
      logic [3:0] rph;
      logic [2:0] rbit;
      logic [7:0] rsh;
      logic rs7;
      logic rs8;
      logic rv;
      logic rpe;
      logic rfe;
      logic rsec;
      logic [7:0] rbuf;
      logic rbfl;
      logic perr;
      logic ferr;
      logic oerr;
      logic armed;
      logic [2:0] ist;
      logic [2:0] imask;
      logic [7:0] rdata;
   } ulc_state_t;

   ulc_state_t s_r, s_nxt;
   ulc_bus_req_t req;
   logic tick, rxi, tx_end, rx_end;
   logic [7:0] stat;

   assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

   // ==========================================================
   // Transfer clock and receive input cleaning
   ulc_baud_gen u_baud (
      .clk(CLK),
      .rst_b(RST_B),
      .sel(s_r.ctrl.clock_select),
      .aux_evt(AUX_TIMER_MATCH_EVENT),
      .tick(tick)
   );

   ulc_noise_filter u_filt (
      .clk(CLK),
      .rst_b(RST_B),
      .pin(SERIAL_IN_PIN),
      .mode(s_r.ropt.receive_noise_filter),
      .level(rxi)
   );

   // Each bit lasts sixteen transfer clock ticks.
   assign tx_end = tick && (s_r.tph == ULC_LAST_TICK);
   assign rx_end = tick && (s_r.rph == ULC_LAST_TICK);

   // Status: parity, framing, overrun, receive full, transmit end, buffer empty.
   assign stat = {s_r.perr, s_r.ferr, s_r.oerr, s_r.rbfl,
                  (s_r.tst == ULC_TX_IDLE) && !s_r.tfull, !s_r.tfull, 2'b00};

   // ==========================================================
   // Next-state logic for the whole block.
   always_comb
   begin
      s_nxt = s_r;

      // Register writes.
      if (req.wr)
      begin
         case (req.addr)
            ULC_LINE_CTRL_ADDR:
            begin
               s_nxt.ctrl = ulc_line_ctrl_t'(req.wdata);
               if (req.wdata[7] && !s_r.ctrl.transmit_enable)
               begin
                  s_nxt.tfull = 1'b0;
               end
            end
            ULC_RX_OPT_ADDR: s_nxt.ropt = ulc_rx_opt_t'(req.wdata[2:0]);
            ULC_DATA_ADDR:
            begin
               // Writes while disabled are dropped so old data cannot leak out later.
               if (s_r.ctrl.transmit_enable)
               begin
                  s_nxt.tbuf = req.wdata;
                  s_nxt.tfull = 1'b1;
               end
            end
            ULC_IRQ_STAT_ADDR: s_nxt.ist = s_r.ist & ~req.wdata[2:0];
            ULC_IRQ_MASK_ADDR: s_nxt.imask = req.wdata[2:0];
            default: ;
         endcase
      end

      // Register reads; a status read arms the flag clear done by a data read.
      s_nxt.rdata = 8'h00;
      if (req.rd)
      begin
         case (req.addr)
            ULC_LINE_CTRL_ADDR:
            begin
               s_nxt.rdata = stat;
               s_nxt.armed = 1'b1;
            end
            ULC_DATA_ADDR:
            begin
               s_nxt.rdata = s_r.rbuf;
               if (s_r.armed)
               begin
                  s_nxt.armed = 1'b0;
                  s_nxt.rbfl = 1'b0;
                  s_nxt.perr = 1'b0;
                  s_nxt.ferr = 1'b0;
                  s_nxt.oerr = 1'b0;
               end
            end
            ULC_IRQ_STAT_ADDR: s_nxt.rdata = {5'h00, s_r.ist};
            ULC_IRQ_MASK_ADDR: s_nxt.rdata = {5'h00, s_r.imask};
            default: ;
         endcase
      end

      // Transmitter. A new frame starts only while enabled, so a clear lets
      // the running frame finish.
      if (tick && (s_r.tst != ULC_TX_IDLE))
      begin
         s_nxt.tph = s_r.tph + 4'h1;
      end
      case (s_r.tst)
         ULC_TX_IDLE:
         begin
            s_nxt.tout = 1'b1;
            if (s_r.ctrl.transmit_enable && s_r.tfull)
            begin
               s_nxt.tsh = s_r.tbuf;
               s_nxt.tfull = s_nxt.tfull && req.wr && (req.addr == ULC_DATA_ADDR);
               s_nxt.tpar = ^s_r.tbuf ^ ~s_r.ctrl.parity_even;
               s_nxt.tph = 4'h0;
               s_nxt.tsec = 1'b0;
               s_nxt.tout = 1'b0;
               s_nxt.tst = ULC_TX_START;
               s_nxt.ist[ULC_IRQ_TX_EMPTY] = 1'b1;
            end
         end
         ULC_TX_START:
         begin
            if (tx_end)
            begin
               s_nxt.tbit = 3'h0;
               s_nxt.tout = s_r.tsh[0];
               s_nxt.tst = ULC_TX_DATA;
            end
         end
         ULC_TX_DATA:
         begin
            if (tx_end)
            begin
               s_nxt.tsh = {1'b0, s_r.tsh[7:1]};
               s_nxt.tbit = s_r.tbit + 3'h1;
               s_nxt.tout = s_r.tsh[1];
               if (s_r.tbit == ULC_LAST_DATA_BIT)
               begin
                  s_nxt.tout = s_r.ctrl.parity_enable ? s_r.tpar : 1'b1;
                  s_nxt.tst = s_r.ctrl.parity_enable ? ULC_TX_PAR : ULC_TX_STOP;
               end
            end
         end
         ULC_TX_PAR:
         begin
            if (tx_end)
            begin
               s_nxt.tout = 1'b1;
               s_nxt.tst = ULC_TX_STOP;
            end
         end
         ULC_TX_STOP:
         begin
            if (tx_end)
            begin
               if (s_r.ctrl.transmit_stop_length && !s_r.tsec)
               begin
                  s_nxt.tsec = 1'b1;
               end
               else
               begin
                  s_nxt.tst = ULC_TX_IDLE;
               end
            end
         end
         default: s_nxt.tst = ULC_TX_IDLE;
      endcase

      // Receiver: majority of ticks 7, 8 and 9, acted on at tick 15.
      if (tick && (s_r.rst != ULC_RX_IDLE))
      begin
         s_nxt.rph = s_r.rph + 4'h1;
         if (s_r.rph == ULC_SAMPLE_A)
         begin
            s_nxt.rs7 = rxi;
         end
         if (s_r.rph == ULC_SAMPLE_B)
         begin
            s_nxt.rs8 = rxi;
         end
         if (s_r.rph == ULC_SAMPLE_C)
         begin
            s_nxt.rv = (s_r.rs7 & s_r.rs8) | (s_r.rs7 & rxi) | (s_r.rs8 & rxi);
         end
      end
      case (s_r.rst)
         ULC_RX_IDLE:
         begin
            // A pending overrun holds the receiver off until software clears it.
            if (tick && !rxi && s_r.ctrl.receive_enable && !s_r.oerr)
            begin
               s_nxt.rph = 4'h1;
               s_nxt.rpe = 1'b0;
               s_nxt.rfe = 1'b0;
               s_nxt.rsec = 1'b0;
               s_nxt.rst = ULC_RX_START;
            end
         end
         ULC_RX_START:
         begin
            if (rx_end)
            begin
               s_nxt.rbit = 3'h0;
               s_nxt.rst = s_r.rv ? ULC_RX_IDLE : ULC_RX_DATA;
            end
         end
         ULC_RX_DATA:
         begin
            if (rx_end)
            begin
               s_nxt.rsh = {s_r.rv, s_r.rsh[7:1]};
               s_nxt.rbit = s_r.rbit + 3'h1;
               if (s_r.rbit == ULC_LAST_DATA_BIT)
               begin
                  s_nxt.rst = s_r.ctrl.parity_enable ? ULC_RX_PAR : ULC_RX_STOP;
               end
            end
         end
         ULC_RX_PAR:
         begin
            if (rx_end)
            begin
               s_nxt.rpe = s_r.rv != (^s_r.rsh ^ ~s_r.ctrl.parity_even);
               s_nxt.rst = ULC_RX_STOP;
            end
         end
         ULC_RX_STOP:
         begin
            if (rx_end)
            begin
               s_nxt.rfe = s_r.rfe | ~s_r.rv;
               if (s_r.ropt.receive_stop_length && !s_r.rsec)
               begin
                  s_nxt.rsec = 1'b1;
               end
               else
               begin
                  // Flag sets come after the read clear, so a set wins.
                  s_nxt.rst = ULC_RX_IDLE;
                  if (s_r.rbfl)
                  begin
                     s_nxt.oerr = 1'b1;
                     s_nxt.ist[ULC_IRQ_RX_ERR] = 1'b1;
                  end
                  else
                  begin
                     s_nxt.rbuf = s_r.rsh;
                     s_nxt.rbfl = 1'b1;
                     s_nxt.perr = s_nxt.perr | s_r.rpe;
                     s_nxt.ferr = s_nxt.ferr | s_nxt.rfe;
                     s_nxt.ist[ULC_IRQ_RX_FULL] = 1'b1;
                     s_nxt.ist[ULC_IRQ_RX_ERR] = s_nxt.ist[ULC_IRQ_RX_ERR] | s_r.rpe
                                                 | s_nxt.rfe;
                  end
               end
            end
         end
         default: s_nxt.rst = ULC_RX_IDLE;
      endcase
   end

   // ==========================================================
   // State register.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         s_r <= '0;
         s_r.ctrl <= ulc_line_ctrl_t'(ULC_LINE_CTRL_RST);
         s_r.ropt <= ulc_rx_opt_t'(ULC_RX_OPT_RST);
         s_r.ist <= ULC_IRQ_RST;
         s_r.imask <= ULC_IRQ_RST;
         s_r.tst <= ULC_TX_IDLE;
         s_r.rst <= ULC_RX_IDLE;
         s_r.tout <= 1'b1;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // ==========================================================
   // Outputs.
   assign RDATA = s_r.rdata;
   assign SERIAL_OUT_PIN = s_r.tout;
   assign IRQ = |(s_r.ist & s_r.imask);

endmodule

// *** hw/ulc_pkg.sv ***
package ulc_pkg;

   // ==========================================================
   // Register map
   localparam logic [11:0] ULC_LINE_CTRL_ADDR = 12'hF95;
   localparam logic [11:0] ULC_RX_OPT_ADDR = 12'hF96;
   localparam logic [11:0] ULC_DATA_ADDR = 12'hF97;
   localparam logic [11:0] ULC_IRQ_STAT_ADDR = 12'hF98;
   localparam logic [11:0] ULC_IRQ_MASK_ADDR = 12'hF99;
   localparam logic [7:0] ULC_LINE_CTRL_RST = 8'h00;
   localparam logic [2:0] ULC_RX_OPT_RST = 3'h0;
   localparam logic [2:0] ULC_IRQ_RST = 3'h0;

   // ==========================================================
   // Interrupt status bit positions
   localparam int ULC_IRQ_TX_EMPTY = 0;
   localparam int ULC_IRQ_RX_FULL = 1;
   localparam int ULC_IRQ_RX_ERR = 2;

   // ==========================================================
   // Timing: divider figures and filter windows in fc periods, oversampling points in transfer clock ticks
   localparam logic [3:0] ULC_LAST_TICK = 4'hF;
   localparam logic [3:0] ULC_SAMPLE_A = 4'h7;
   localparam logic [3:0] ULC_SAMPLE_B = 4'h8;
   localparam logic [3:0] ULC_SAMPLE_C = 4'h9;
   localparam logic [2:0] ULC_LAST_DATA_BIT = 3'h7;
   localparam logic [2:0] ULC_SEL_TIMER = 3'h6;
   localparam logic [8:0] ULC_DIV_0 = 9'h00D;
   localparam logic [8:0] ULC_DIV_1 = 9'h01A;
   localparam logic [8:0] ULC_DIV_2 = 9'h034;
   localparam logic [8:0] ULC_DIV_3 = 9'h068;
   localparam logic [8:0] ULC_DIV_4 = 9'h0D0;
   localparam logic [8:0] ULC_DIV_5 = 9'h1A0;
   localparam logic [8:0] ULC_DIV_7 = 9'h060;
   localparam logic [6:0] ULC_FILT_1 = 7'h1F;
   localparam logic [6:0] ULC_FILT_2 = 7'h3F;
   localparam logic [6:0] ULC_FILT_3 = 7'h7F;

   // ==========================================================
   // Types
   typedef struct packed {
      logic transmit_enable;
      logic receive_enable;
      logic transmit_stop_length;
      logic parity_even;
      logic parity_enable;
      logic [2:0] clock_select;
   } ulc_line_ctrl_t;

   typedef struct packed {
      logic [1:0] receive_noise_filter;
      logic receive_stop_length;
   } ulc_rx_opt_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } ulc_bus_req_t;

   typedef enum logic [4:0] {
      ULC_TX_IDLE = 5'h01,
      ULC_TX_START = 5'h02,
      ULC_TX_DATA = 5'h04,
      ULC_TX_PAR = 5'h08,
      ULC_TX_STOP = 5'h10
   } ulc_tx_state_t;

   typedef enum logic [4:0] {
      ULC_RX_IDLE = 5'h01,
      ULC_RX_START = 5'h02,
      ULC_RX_DATA = 5'h04,
      ULC_RX_PAR = 5'h08,
      ULC_RX_STOP = 5'h10
   } ulc_rx_state_t;

endpackage

// *** hw/ulc_baud_gen.sv ***
`timescale 1ns/10ps
module ulc_baud_gen
   import ulc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Selection and timer events
   input wire logic [2:0] sel,
   input wire logic aux_evt,
   // Sixteen-times transfer clock tick
   output logic tick
);

   // ==========================================================
   // Divider lookup
   function automatic logic [8:0] div_of(input logic [2:0] code);
      case (code)
         3'h0: div_of = ULC_DIV_0;
         3'h1: div_of = ULC_DIV_1;
         3'h2: div_of = ULC_DIV_2;
         3'h3: div_of = ULC_DIV_3;
         3'h4: div_of = ULC_DIV_4;
         3'h5: div_of = ULC_DIV_5;
         default: div_of = ULC_DIV_7;
      endcase
   endfunction

   logic [8:0] cnt_r, cnt_nxt;
   logic [2:0] sel_r, sel_nxt;
   logic tick_r, tick_nxt;

   // ==========================================================
   // Count fc periods; a select change restarts the count cleanly.
   always_comb
   begin
      sel_nxt = sel;
      cnt_nxt = cnt_r + 9'h001;
      tick_nxt = 1'b0;
      if (sel != sel_r)
      begin
         cnt_nxt = 9'h000;
      end
      else if (sel == ULC_SEL_TIMER)
      begin
         cnt_nxt = 9'h000;
         tick_nxt = aux_evt;
      end
      else if (cnt_r == div_of(sel) - 9'h001)
      begin
         cnt_nxt = 9'h000;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cnt_r <= 9'h000;
         sel_r <= 3'h0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         sel_r <= sel_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

endmodule

// *** hw/ulc_noise_filter.sv ***
`timescale 1ns/10ps
module ulc_noise_filter
   import ulc_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Pin and filter mode
   input wire logic pin,
   input wire logic [1:0] mode,
   // Cleaned level
   output logic level
);

   logic s1_r, s2_r, lvl_r, lvl_nxt;
   logic [6:0] cnt_r, cnt_nxt, thr;

   // ==========================================================
   // Synchroniser: the first stage feeds only the second.
   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         s1_r <= 1'b1;
         s2_r <= 1'b1;
      end
      else
      begin
         s1_r <= pin;
         s2_r <= s1_r;
      end
   end

   // ==========================================================
   // A new level is taken once it has stood for the whole window, so
   // short glitches vanish and long pulses always pass.
   always_comb
   begin
      case (mode)
         2'h1: thr = ULC_FILT_1;
         2'h2: thr = ULC_FILT_2;
         default: thr = ULC_FILT_3;
      endcase
      lvl_nxt = lvl_r;
      cnt_nxt = 7'h00;
      if (mode == 2'h0)
      begin
         lvl_nxt = s2_r;
      end
      else if (s2_r != lvl_r)
      begin
         cnt_nxt = cnt_r + 7'h01;
         if (cnt_nxt >= thr)
         begin
            lvl_nxt = s2_r;
            cnt_nxt = 7'h00;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         lvl_r <= 1'b1;
         cnt_r <= 7'h00;
      end
      else
      begin
         lvl_r <= lvl_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign level = lvl_r;

endmodule

// *** tb/ulc_uart_line_config_assertions.sv ***
`timescale 1ns/10ps
// ==========================================
// Port checker for the serial line core
module ulc_chk
   import ulc_pkg::*;
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Register port
   input wire logic [11:0] ADDR,
   input wire logic [7:0] WDATA,
   input wire logic WR,
   input wire logic RD,
   input wire logic [7:0] RDATA,
   // Line, timer and interrupt
   input wire logic SERIAL_IN_PIN,
   input wire logic SERIAL_OUT_PIN,
   input wire logic AUX_TIMER_MATCH_EVENT,
   input wire logic IRQ
);
   logic en_r;
   logic hold_r;
   logic [2:0] mask_r;
   logic wr_line;
   logic wr_data;
   logic unmapped;

   // Decoded software accesses.
   assign wr_line = WR && ADDR == ULC_LINE_CTRL_ADDR;
   assign wr_data = WR && ADDR == ULC_DATA_ADDR;
   assign unmapped = ADDR < ULC_LINE_CTRL_ADDR || ADDR > ULC_IRQ_MASK_ADDR;

   // Shadow of the writes; hold_r spans enable up to the first fresh byte.
   // Re-enabling in mid-frame is not modelled, so the bench never does it.
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         en_r <= 1'b0;
         hold_r <= 1'b1;
         mask_r <= 3'h0;
      end
      else
      begin
         if (wr_line)
            en_r <= WDATA[7];
         if (wr_line && WDATA[7] && !en_r)
            hold_r <= 1'b1;
         else if (wr_data && en_r)
            hold_r <= 1'b0;
         if (WR && ADDR == ULC_IRQ_MASK_ADDR)
            mask_r <= WDATA[2:0];
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_rdata_quiet: assert property (!RD |=> RDATA == 8'h00)
      else $error("read data not zero outside an answer");
   a_unmapped_read: assert property (RD && unmapped |=> RDATA == 8'h00)
      else $error("unmapped read returned data");
   a_status_low: assert property (RD && ADDR == ULC_LINE_CTRL_ADDR |=> RDATA[1:0] == 2'b00)
      else $error("status low bits not zero");
   a_irq_width: assert property (RD && ADDR == ULC_IRQ_STAT_ADDR |=> RDATA[7:3] == 5'h00)
      else $error("interrupt status upper bits set");
   a_irq_masked: assert property (mask_r == 3'h0 |-> !IRQ)
      else $error("interrupt raised with all sources masked");
   a_pin_idle: assert property (hold_r |-> SERIAL_OUT_PIN)
      else $error("transmit pin left idle level");
   a_frame_start: assert property (hold_r && en_r && wr_data |-> ##[1:2] !SERIAL_OUT_PIN)
      else $error("fresh byte did not start a frame");
   a_reset_state: assert property ($rose(RST_B) |-> SERIAL_OUT_PIN && !IRQ && RDATA == 8'h00)
      else $error("outputs wrong after reset release");

   c_frame: cover property (hold_r && en_r && wr_data);
   c_irq: cover property (IRQ);
   c_read: cover property (RD && ADDR == ULC_DATA_ADDR ##1 RDATA != 8'h00);
endmodule

bind ulc_uart_line_config ulc_chk u_chk (
   .CLK(CLK), .RST_B(RST_B), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
   .SERIAL_IN_PIN(SERIAL_IN_PIN), .SERIAL_OUT_PIN(SERIAL_OUT_PIN),
   .AUX_TIMER_MATCH_EVENT(AUX_TIMER_MATCH_EVENT), .IRQ(IRQ));

// *** tb/ulc_peer.sv ***
`timescale 1ns/10ps
// ==========================================
// Remote serial peer on the line
module ulc_peer
(
   // Clock
   input wire logic clk,
   // Line toward the core
   input wire logic line_in,
   output logic line_out
);
   initial line_out = 1'b1;

   // Start low, data LSB first, optional parity, high stop bits.
   task automatic send(input logic [7:0] d, input logic par, input logic even,
                       input logic bad, input int nstop, input int bc);
      logic p;
      p = ^d ^ !even ^ bad;
      line_out <= 1'b0;
      repeat (bc) @(posedge clk);
      for (int i = 0; i < 9; i++)
      begin
         if (i < 8 || par)
         begin
            line_out <= (i < 8) ? d[i] : p;
            repeat (bc) @(posedge clk);
         end
      end
      line_out <= 1'b1;
      repeat (nstop * bc) @(posedge clk);
   endtask

   // A short low pulse on an idle line.
   task automatic glitch(input int n);
      line_out <= 1'b0;
      repeat (n) @(posedge clk);
      line_out <= 1'b1;
   endtask

   // Decodes one frame mid-bit; syncs on the d0 edge, so d0 must be one.
   // The first start bit may be short, which is why it is not trusted.
   task automatic recv(input int bc, output logic [7:0] d, output logic [2:0] t);
      @(negedge line_in);
      @(posedge line_in);
      repeat (bc / 2) @(posedge clk);
      d[0] = line_in;
      for (int i = 1; i < 11; i++)
      begin
         repeat (bc) @(posedge clk);
         if (i < 8)
            d[i] = line_in;
         else
            t[i - 8] = line_in;
      end
   endtask

   // Width in cycles of a high d0 bit.
   task automatic d0_width(output int n);
      realtime t0;
      @(negedge line_in);
      @(posedge line_in);
      t0 = $realtime;
      @(negedge line_in);
      n = int'(($realtime - t0) / 10.0);
   endtask
endmodule

// *** tb/ulc_uart_line_config_test.sv ***
`timescale 1ns/10ps
// ==========================================
// Self-checking bench for the serial line core
module ulc_uart_line_config_test
   import ulc_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic aux = 1'b0;
   logic [2:0] aux_cnt = 3'h0;
   logic [7:0] rdata;
   logic sin;
   logic sout;
   logic irq;
   int mismatches = 0;
   int num_checks = 0;

   // Clock and auxiliary timer stand-in, one match every five cycles.
   always #5 clk = ~clk;
   always @(posedge clk)
   begin
      aux_cnt <= (aux_cnt == 3'h4) ? 3'h0 : aux_cnt + 3'h1;
      aux <= (aux_cnt == 3'h4);
   end

   ulc_uart_line_config u_dut (
      .CLK(clk), .RST_B(rst_b), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
      .SERIAL_IN_PIN(sin), .SERIAL_OUT_PIN(sout), .AUX_TIMER_MATCH_EVENT(aux), .IRQ(irq));
   ulc_peer u_peer (.clk(clk), .line_in(sout), .line_out(sin));

   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Bus cycles; the trailing edge keeps two strobes from meeting in one step.
   task automatic wrr(input logic [11:0] a, input logic [7:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
      logic [7:0] d;
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
      @(posedge clk);
      check($sformatf("reg %h", a), 16'(exp), 16'(d));
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask

   task automatic t_reset();
      #1 check("pin", 16'h1, 16'(sout));
      check("irq", 16'h0, 16'(irq));
      @(posedge clk);
      rchk(ULC_LINE_CTRL_ADDR, 8'h0C);
      rchk(12'hF9A, 8'h00);
      $display("reset test done");
   endtask

   task automatic t_tx();
      logic [7:0] d;
      logic [2:0] t;
      wrr(ULC_DATA_ADDR, 8'h33);
      wrr(ULC_IRQ_MASK_ADDR, 8'h01);
      wrr(ULC_LINE_CTRL_ADDR, 8'hB8);
      repeat (300) @(posedge clk);
      check("idle pin", 16'h1, 16'(sout));
      fork
         u_peer.recv(208, d, t);
         begin
            wrr(ULC_DATA_ADDR, 8'h55);
            wrr(ULC_DATA_ADDR, 8'hA5);
         end
      join
      check("tx data", 16'h55, 16'(d));
      check("tx tail", 16'h6, 16'(t));
      fork
         u_peer.recv(208, d, t);
         begin
            @(negedge sout);
            repeat (40) @(posedge clk);
            wrr(ULC_LINE_CTRL_ADDR, 8'h38);
         end
      join
      check("tx data", 16'hA5, 16'(d));
      check("tx tail", 16'h6, 16'(t));
      repeat (300) @(posedge clk);
      check("off pin", 16'h1, 16'(sout));
      wrr(ULC_LINE_CTRL_ADDR, 8'h88);
      fork
         u_peer.recv(208, d, t);
         begin
            wrr(ULC_DATA_ADDR, 8'h55);
            wrr(ULC_DATA_ADDR, 8'h55);
         end
      join
      check("tx tail", 16'h3, 16'(t));
      repeat (2600) @(posedge clk);
      check("irq", 16'h1, 16'(irq));
      rchk(ULC_IRQ_STAT_ADDR, 8'h01);
      wrr(ULC_IRQ_STAT_ADDR, 8'h01);
      check("irq", 16'h0, 16'(irq));
      $display("transmit test done");
   endtask

   task automatic t_rx();
      wrr(ULC_LINE_CTRL_ADDR, 8'h58);
      wrr(ULC_RX_OPT_ADDR, 8'hF9);
      u_peer.send(8'h3C, 1'b1, 1'b1, 1'b0, 2, 208);
      repeat (400) @(posedge clk);
      check("irq", 16'h0, 16'(irq));
      wrr(ULC_IRQ_MASK_ADDR, 8'h02);
      check("irq", 16'h1, 16'(irq));
      rchk(ULC_LINE_CTRL_ADDR, 8'h1C);
      rchk(ULC_DATA_ADDR, 8'h3C);
      rchk(ULC_LINE_CTRL_ADDR, 8'h0C);
      wrr(ULC_IRQ_STAT_ADDR, 8'h02);
      check("irq", 16'h0, 16'(irq));
      u_peer.send(8'h3C, 1'b1, 1'b1, 1'b1, 2, 208);
      repeat (400) @(posedge clk);
      rchk(ULC_LINE_CTRL_ADDR, 8'h9C);
      rchk(ULC_DATA_ADDR, 8'h3C);
      wrr(ULC_RX_OPT_ADDR, 8'h02);
      // A train of short lows; a receiver that let them through would see a
      // mostly low line and load a frame, so the status read below can trip.
      repeat (120)
      begin
         u_peer.glitch(20);
         repeat (6) @(posedge clk);
      end
      repeat (2600) @(posedge clk);
      rchk(ULC_LINE_CTRL_ADDR, 8'h0C);
      wrr(ULC_RX_OPT_ADDR, 8'h06);
      u_peer.send(8'h81, 1'b1, 1'b1, 1'b0, 1, 208);
      repeat (400) @(posedge clk);
      rchk(ULC_DATA_ADDR, 8'h81);
      $display("receive test done");
   endtask

   // Each select code restarts from reset, which also clears both enables.
   task automatic t_clk();
      int div [8] = '{13, 26, 52, 104, 208, 416, 5, 96};
      int n;
      for (int c = 0; c < 8; c++)
      begin
         do_reset();
         wrr(ULC_LINE_CTRL_ADDR, 8'h80 | 8'(c));
         fork
            u_peer.d0_width(n);
            wrr(ULC_DATA_ADDR, 8'h55);
         join
         check("bit time", 16'(16 * div[c]), 16'(n));
      end
      $display("clock select test done");
   endtask

   // Watchdog well above the roughly 55k cycles the tests take.
   initial
   begin
      repeat (90000) @(posedge clk);
      mismatches++;
      finish_test();
   end

   initial
   begin
      do_reset();
      t_reset();
      t_tx();
      t_rx();
      t_clk();
      finish_test();
   end
endmodule
